// ===== rtl/eph_host_port.sv
// Module: serial host port of an e-paper controller
`timescale 1ns/1ps
// Function
// - Serial traffic is accepted only while chip select is low.
// - In 4-wire mode select high means data, low means command.
// - Strap low gives 4-wire 8-bit words, high gives 3-wire 9-bit words.
// - 4-wire writes sample data on rising serial clock, MSB first.
// - Select held per byte; completed byte routed by that level.
// - Read bytes leave MSB first, changing on falling serial clock.
// - 3-wire words: leading flag bit then eight payload bits MSB first.
// - 3-wire read: host sends leading 1, device shifts out eight bits.
// - Low on the hard reset input resets the port.
// - Busy high during waveform output or temperature sensor traffic.
// - Software reset command clears parameters, holds busy while running.
module eph_host_port
  import eph_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  input wire logic hard_init_n,
  // Serial pins, sampled synchronously
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic dc_sel,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic bus_width_strap,
  // Core side
  input wire logic wave_active,
  input wire logic temp_active,
  input wire logic [7:0] read_byte,
  output logic read_req,
  output logic [7:0] read_cmd,
  output logic busy,
  output logic param_reset,
  output logic word_valid,
  input wire logic word_ready,
  output eph_pkg::eph_word_t word_out
);
  import eph_pkg::*;

  function automatic logic is_read_cmd(input logic [7:0] c);
    return c == EPH_CMD_RD_1B || c == EPH_CMD_RD_27 || c == EPH_CMD_RD_2D ||
           c == EPH_CMD_RD_2E || c == EPH_CMD_RD_2F || c == EPH_CMD_RD_35;
  endfunction

  logic rst_n;
  logic sclk_reg, sclk_next, cs_reg, cs_next, strap_reg, strap_next;
  eph_state_t st_reg, st_next;
  logic [3:0] cnt_reg, cnt_next;
  logic [8:0] sh_reg, sh_next;
  logic [7:0] out_reg, out_next, cmd_reg, cmd_next;
  logic rd_mode_reg, rd_mode_next;
  logic sda_o_reg, sda_o_next, sda_oe_reg, sda_oe_next, rdreq_reg, rdreq_next;
  logic [7:0] swrst_reg, swrst_next;
  logic busy_reg, busy_next, prst_reg, prst_next;
  logic push_valid;
  eph_word_t push_word;
  logic fifo_valid, fifo_pop;
  logic [EPH_DATA_W-1:0] fifo_data;
  logic wv_reg, wv_next;
  eph_word_t wo_reg, wo_next;
  logic rise, fall, sel, word_done;
  logic [3:0] nbits;

  assign rst_n = resetn && hard_init_n;

  always_comb begin
    sclk_next = sclk;
    cs_next = cs_n;
    strap_next = (cs_n && cs_reg) ? bus_width_strap : strap_reg;
    rise = !cs_n && sclk && !sclk_reg;
    fall = !cs_n && !sclk && sclk_reg;
    nbits = strap_reg ? EPH_BITS_3W : EPH_BITS_4W;
    st_next = st_reg;
    cnt_next = cnt_reg;
    sh_next = sh_reg;
    out_next = out_reg;
    cmd_next = cmd_reg;
    rd_mode_next = rd_mode_reg;
    sda_o_next = sda_o_reg;
    sda_oe_next = 1'b0;
    rdreq_next = 1'b0;
    push_valid = 1'b0;
    word_done = 1'b0;
    sel = strap_reg ? sh_reg[8] : dc_sel;
    push_word = '{is_data: sel, payload: sh_reg[7:0]};
    if (cs_n) begin
      st_next = EPH_IDLE;
      cnt_next = EPH_BITCNT_RST;
      sh_next = '0;
    end else begin
      case (st_reg)
        EPH_IDLE, EPH_SHIFT_IN: begin
          st_next = EPH_SHIFT_IN;
          if (!strap_reg && cnt_reg == EPH_BITCNT_RST && dc_sel && rd_mode_reg) begin
            // 4-wire read: first bit must stand before the first rising edge
            st_next = EPH_SHIFT_OUT;
            cnt_next = 4'h1;
            sda_o_next = read_byte[7];
            out_next = {read_byte[6:0], 1'b0};
            rdreq_next = 1'b1;
          end else if (rise) begin
            sh_next = {sh_reg[7:0], sda_in};
            cnt_next = cnt_reg + 4'h1;
            // 3-wire read: leading data flag starts shift out
            if (strap_reg && cnt_reg == EPH_BITCNT_RST && sda_in && rd_mode_reg) begin
              st_next = EPH_SHIFT_OUT;
              cnt_next = EPH_BITCNT_RST;
              out_next = read_byte;
              rdreq_next = 1'b1;
            end
          end
          if (cnt_reg == nbits) begin
            word_done = 1'b1;
            cnt_next = rise ? 4'h1 : EPH_BITCNT_RST;
          end
        end
        EPH_SHIFT_OUT: begin
          sda_oe_next = 1'b1;
          if (fall) begin
            if (cnt_reg == EPH_BITS_4W) begin
              // Byte done: free the line for the next flag bit or byte
              st_next = EPH_SHIFT_IN;
              cnt_next = EPH_BITCNT_RST;
              sda_oe_next = 1'b0;
            end else begin
              sda_o_next = out_reg[7];
              out_next = {out_reg[6:0], 1'b0};
              cnt_next = cnt_reg + 4'h1;
            end
          end
        end
        default: st_next = EPH_IDLE;
      endcase
    end
    if (word_done) begin
      push_valid = 1'b1;
      if (!sel) begin
        cmd_next = sh_reg[7:0];
        rd_mode_next = is_read_cmd(sh_reg[7:0]);
      end
    end
  end

  // Software reset and busy
  always_comb begin
    swrst_next = (swrst_reg != 8'h00) ? swrst_reg - 8'h01 : 8'h00;
    prst_next = 1'b0;
    if (word_done && !sel && sh_reg[7:0] == EPH_CMD_SWRESET) begin
      swrst_next = EPH_SWRST_CNT;
      prst_next = 1'b1;
    end
    busy_next = wave_active || temp_active || (swrst_next != 8'h00);
    // Valid drops for one cycle after a pop so no word is shown twice
    fifo_pop = word_ready && wv_reg;
    wv_next = fifo_valid && !fifo_pop;
    wo_next = eph_word_t'(fifo_data);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sclk_reg <= 1'b0;
      cs_reg <= 1'b1;
      strap_reg <= 1'b0;
      st_reg <= EPH_IDLE;
      cnt_reg <= EPH_BITCNT_RST;
      sh_reg <= '0;
      out_reg <= EPH_BYTE_RST;
      cmd_reg <= EPH_BYTE_RST;
      rd_mode_reg <= 1'b0;
      sda_o_reg <= 1'b0;
      sda_oe_reg <= 1'b0;
      rdreq_reg <= 1'b0;
      swrst_reg <= 8'h00;
      busy_reg <= 1'b0;
      prst_reg <= 1'b0;
      wv_reg <= 1'b0;
      wo_reg <= '0;
    end else begin
      sclk_reg <= sclk_next;
      cs_reg <= cs_next;
      strap_reg <= strap_next;
      st_reg <= st_next;
      cnt_reg <= cnt_next;
      sh_reg <= sh_next;
      out_reg <= out_next;
      cmd_reg <= cmd_next;
      rd_mode_reg <= rd_mode_next;
      sda_o_reg <= sda_o_next;
      sda_oe_reg <= sda_oe_next;
      rdreq_reg <= rdreq_next;
      swrst_reg <= swrst_next;
      busy_reg <= busy_next;
      prst_reg <= prst_next;
      wv_reg <= wv_next;
      wo_reg <= wo_next;
    end
  end

  eph_fifo #(.WIDTH(EPH_DATA_W), .DEPTH(EPH_FIFO_DEPTH), .AW(EPH_FIFO_AW)) u_fifo (
    .clk(clk),
    .resetn(rst_n),
    .in_valid(push_valid),
    .in_ready(),
    .in_data(push_word),
    .out_valid(fifo_valid),
    .out_ready(fifo_pop),
    .out_data(fifo_data)
  );

  assign sda_out = sda_o_reg;
  assign sda_oe = sda_oe_reg;
  assign read_req = rdreq_reg;
  assign read_cmd = cmd_reg;
  assign busy = busy_reg;
  assign param_reset = prst_reg;
  assign word_valid = wv_reg;
  assign word_out = wo_reg;

  a_cs_release: assert property (@(posedge clk) disable iff (!rst_n)
    cs_n |=> !sda_oe) else $error("data line driven while deselected");
  a_busy_swrst: assert property (@(posedge clk) disable iff (!rst_n)
    prst_reg |-> busy_reg) else $error("busy low during soft reset");
  a_busy_cause: assert property (@(posedge clk) disable iff (!rst_n)
    $past(wave_active) |-> busy_reg) else $error("busy low during waveform");
  a_idle_count: assert property (@(posedge clk) disable iff (!rst_n)
    cs_n |=> cnt_reg == EPH_BITCNT_RST) else $error("partial word kept");
  a_word_width: assert property (@(posedge clk) disable iff (!rst_n)
    st_reg != EPH_SHIFT_OUT |-> cnt_reg <= EPH_BITS_3W) else $error("bit count overrun");
  a_push_cs: assert property (@(posedge clk) disable iff (!rst_n)
    push_valid |-> !cs_n) else $error("word taken while deselected");
  a_cmd_route: assert property (@(posedge clk) disable iff (!rst_n)
    word_done && !sel |=> cmd_reg == $past(sh_reg[7:0])) else $error("command not latched");
  a_out_drive: assert property (@(posedge clk) disable iff (!rst_n)
    rdreq_reg && !cs_n |=> sda_oe_reg) else $error("read byte not driven");
endmodule // eph_host_port

// ===== inc/eph_pkg.sv
// Package: constants and carriers of the e-paper serial host port
package eph_pkg;
  localparam int EPH_DATA_W = 9;
  localparam int EPH_FIFO_DEPTH = 16;
  localparam int EPH_FIFO_AW = 4;
  localparam logic [3:0] EPH_BITS_4W = 4'h8;
  localparam logic [3:0] EPH_BITS_3W = 4'h9;
  localparam logic [7:0] EPH_CMD_SWRESET = 8'h12;
  localparam logic [7:0] EPH_CMD_RD_1B = 8'h1B;
  localparam logic [7:0] EPH_CMD_RD_27 = 8'h27;
  localparam logic [7:0] EPH_CMD_RD_2D = 8'h2D;
  localparam logic [7:0] EPH_CMD_RD_2E = 8'h2E;
  localparam logic [7:0] EPH_CMD_RD_2F = 8'h2F;
  localparam logic [7:0] EPH_CMD_RD_35 = 8'h35;
  localparam logic [3:0] EPH_BITCNT_RST = 4'h0;
  localparam logic [7:0] EPH_BYTE_RST = 8'h00;
  // Software reset duration
  localparam int EPH_SWRST_NS = 1000;
  localparam int EPH_CLK_NS = 25;
  localparam int EPH_SWRST_CYC = (EPH_SWRST_NS + EPH_CLK_NS - 1) / EPH_CLK_NS;
  localparam logic [7:0] EPH_SWRST_CNT = 8'(EPH_SWRST_CYC);

  typedef struct packed {
    logic is_data;
    logic [7:0] payload;
  } eph_word_t;

  typedef enum logic [1:0] {
    EPH_IDLE = 2'b00,
    EPH_SHIFT_IN = 2'b01,
    EPH_SHIFT_OUT = 2'b11
  } eph_state_t;
endpackage

// ===== rtl/eph_fifo.sv
// Module: parameterised FIFO for received words
`timescale 1ns/1ps
module eph_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 16,
  parameter int AW = 4
) (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_reg, wr_next, rd_reg, rd_next;
  logic [WIDTH-1:0] dout_reg, dout_next;
  logic full, empty, push, pop;

  always_comb begin
    full = (wr_reg[AW] != rd_reg[AW]) && (wr_reg[AW-1:0] == rd_reg[AW-1:0]);
    empty = (wr_reg == rd_reg);
    push = in_valid && !full;
    pop = out_ready && !empty;
    wr_next = wr_reg + (AW+1)'(push);
    rd_next = rd_reg + (AW+1)'(pop);
    in_ready = !full;
    out_valid = !empty;
    out_data = dout_reg;
    // Head word of the next cycle, bypassing a write into that slot
    dout_next = mem[rd_next[AW-1:0]];
    if (push && wr_reg[AW-1:0] == rd_next[AW-1:0]) begin
      dout_next = in_data;
    end
  end

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_reg[AW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wr_reg <= '0;
      rd_reg <= '0;
      dout_reg <= '0;
    end else begin
      wr_reg <= wr_next;
      rd_reg <= rd_next;
      dout_reg <= dout_next;
    end
  end
endmodule // eph_fifo

// ===== tb/eph_host_model.sv
// Host model: serial bus master driving the e-paper host port
`timescale 1ns/1ps
module eph_host_model (
  // Clock
  input wire logic clk,
  // Serial pins
  output logic cs_n,
  output logic sclk,
  output logic dc_sel,
  output logic sda_in,
  output logic bus_width_strap,
  input wire logic sda_out,
  input wire logic sda_oe
);
  logic host_d = 1'b0;
  logic host_drv = 1'b0;
  initial cs_n = 1'b1;
  initial sclk = 1'b0;
  initial dc_sel = 1'b0;
  initial bus_width_strap = 1'b0;
  // Released line shows the inverse of the last bit
  assign sda_in = sda_oe ? sda_out : (host_drv ? host_d : ~host_d);

  task automatic wait_clk(input int n);
    repeat (n) @(posedge clk);
  endtask

  // Strap only changes while chip select is high
  task automatic set_mode(input logic m);
    bus_width_strap <= m;
    wait_clk(4);
  endtask

  // Data changes while the serial clock is low
  task automatic bit_out(input logic b, input int h);
    host_d <= b;
    wait_clk(h);
    sclk <= 1'b1;
    wait_clk(h);
    sclk <= 1'b0;
  endtask

  // Sends one word; nd trailing bits are dropped to cut it short
  task automatic word(input logic is_data, input logic [7:0] v, input int nd, input logic keep);
    logic [8:0] w;
    int n;
    w = {is_data, v};
    n = bus_width_strap ? 9 : 8;
    @(posedge clk);
    cs_n <= 1'b0;
    dc_sel <= is_data & ~bus_width_strap;
    host_drv <= 1'b1;
    wait_clk(3);
    for (int i = n - 1; i >= nd; i--) bit_out(w[i], 4);
    wait_clk(3);
    host_drv <= 1'b0;
    cs_n <= keep ? 1'b0 : 1'b1;
    wait_clk(4);
  endtask

  // Reads one byte after a read command, sampling before each rise
  task automatic rd(output logic [7:0] v);
    dc_sel <= ~bus_width_strap;
    if (bus_width_strap) begin
      host_drv <= 1'b1;
      bit_out(1'b1, 8);
      host_drv <= 1'b0;
    end
    for (int i = 7; i >= 0; i--) begin
      wait_clk(8);
      v[i] = sda_oe ? sda_out : 1'bx;
      sclk <= 1'b1;
      wait_clk(8);
      sclk <= 1'b0;
    end
    wait_clk(8);
    cs_n <= 1'b1;
    wait_clk(10);
  endtask
endmodule // eph_host_model

// ===== tb/tb_eph_host_port.sv
// Testbench: self-checking scenarios for the e-paper serial host port
`timescale 1ns/1ps
module tb_eph_host_port;
  import eph_pkg::*;
  localparam logic [7:0] RD_CMDS [6] = '{EPH_CMD_RD_1B, EPH_CMD_RD_27, EPH_CMD_RD_2D,
    EPH_CMD_RD_2E, EPH_CMD_RD_2F, EPH_CMD_RD_35};
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic hard_init_n = 1'b1;
  logic wave_active = 1'b0;
  logic temp_active = 1'b0;
  logic [7:0] read_byte = 8'h00;
  logic word_ready = 1'b0;
  logic cs_n, sclk, dc_sel, sda_in, sda_out, sda_oe, bus_width_strap;
  logic read_req, busy, param_reset, word_valid;
  logic [7:0] read_cmd;
  eph_word_t word_out;
  int n_fail = 0;
  int total_checks = 0;
  int n_req = 0;
  int n_prst = 0;
  int n_busy = 0;

  initial forever #12.5 clk = ~clk;

  eph_host_port dut_u (
    .clk(clk), .resetn(resetn), .hard_init_n(hard_init_n), .cs_n(cs_n), .sclk(sclk),
    .dc_sel(dc_sel), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe),
    .bus_width_strap(bus_width_strap), .wave_active(wave_active), .temp_active(temp_active),
    .read_byte(read_byte), .read_req(read_req), .read_cmd(read_cmd), .busy(busy),
    .param_reset(param_reset), .word_valid(word_valid), .word_ready(word_ready),
    .word_out(word_out)
  );
  eph_host_model host_u (
    .clk(clk), .cs_n(cs_n), .sclk(sclk), .dc_sel(dc_sel), .sda_in(sda_in),
    .bus_width_strap(bus_width_strap), .sda_out(sda_out), .sda_oe(sda_oe)
  );

  always @(posedge clk) begin
    if (read_req === 1'b1) n_req <= n_req + 1;
    if (param_reset === 1'b1) n_prst <= n_prst + 1;
    if (busy === 1'b1) n_busy <= n_busy + 1;
  end

  task automatic chk(input logic [8:0] got, input logic [8:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic final_report;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic pop(input logic [8:0] exp);
    int n;
    n = 0;
    @(negedge clk);
    while (word_valid !== 1'b1 && n < 200) begin
      @(negedge clk);
      n++;
    end
    chk({8'h00, word_valid}, 9'h001, "valid");
    chk(word_out, exp, "word");
    @(posedge clk);
    word_ready <= 1'b1;
    @(posedge clk);
    word_ready <= 1'b0;
    @(posedge clk);
  endtask

  task automatic t_write;
    host_u.word(1'b0, 8'h3C, 0, 1'b0);
    host_u.word(1'b1, 8'hA5, 0, 1'b0);
    pop({1'b0, 8'h3C});
    pop({1'b1, 8'hA5});
    host_u.set_mode(1'b1);
    host_u.word(1'b0, 8'h5A, 0, 1'b0);
    host_u.word(1'b1, 8'h81, 0, 1'b0);
    pop({1'b0, 8'h5A});
    pop({1'b1, 8'h81});
    host_u.set_mode(1'b0);
    host_u.word(1'b1, 8'hFF, 5, 1'b0);
    host_u.word(1'b1, 8'h42, 0, 1'b0);
    pop({1'b1, 8'h42});
    chk({8'h00, word_valid}, 9'h000, "partial");
  endtask

  task automatic t_read;
    logic [7:0] v;
    int r;
    for (int i = 0; i < 6; i++) begin
      host_u.set_mode(i[0]);
      r = n_req;
      read_byte <= 8'hC6 ^ 8'(i);
      host_u.word(1'b0, RD_CMDS[i], 0, 1'b1);
      host_u.rd(v);
      chk({1'b0, v}, {1'b0, 8'hC6 ^ 8'(i)}, "read");
      chk({1'b0, read_cmd}, {1'b0, RD_CMDS[i]}, "cmd");
      // 4-wire: select stays high, so a next byte starts at the last fall
      chk(9'(n_req - r), i[0] ? 9'h001 : 9'h002, "req");
      chk({8'h00, sda_oe}, 9'h000, "oe");
      pop({1'b0, RD_CMDS[i]});
    end
    host_u.set_mode(1'b0);
  endtask

  task automatic t_busy;
    int b;
    int p;
    b = n_busy;
    p = n_prst;
    host_u.word(1'b0, EPH_CMD_SWRESET, 0, 1'b0);
    pop({1'b0, EPH_CMD_SWRESET});
    repeat (80) @(posedge clk);
    chk({8'h00, busy}, 9'h000, "settled");
    b = n_busy - b;
    chk({8'h00, b >= EPH_SWRST_CYC - 1 && b <= EPH_SWRST_CYC + 2}, 9'h001, "swrst");
    chk(9'(n_prst - p), 9'h001, "prst");
    wave_active <= 1'b1;
    repeat (4) @(posedge clk);
    chk({8'h00, busy}, 9'h001, "wave");
    wave_active <= 1'b0;
    temp_active <= 1'b1;
    repeat (4) @(posedge clk);
    chk({8'h00, busy}, 9'h001, "temp");
    temp_active <= 1'b0;
    repeat (4) @(posedge clk);
    chk({8'h00, busy}, 9'h000, "idle");
  endtask

  task automatic t_fifo;
    for (int i = 0; i < 17; i++) host_u.word(1'b1, 8'h10 + 8'(i), 0, 1'b0);
    for (int i = 0; i < 16; i++) pop({1'b1, 8'h10 + 8'(i)});
    repeat (4) @(posedge clk);
    chk({8'h00, word_valid}, 9'h000, "drained");
    host_u.word(1'b1, 8'h77, 0, 1'b0);
    hard_init_n <= 1'b0;
    repeat (2) @(posedge clk);
    hard_init_n <= 1'b1;
    repeat (3) @(posedge clk);
    chk({8'h00, word_valid}, 9'h000, "hard");
    host_u.word(1'b1, 8'h99, 0, 1'b0);
    pop({1'b1, 8'h99});
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    final_report();
  end

  initial begin
    repeat (10) @(posedge clk);
    resetn <= 1'b1;
    repeat (2) @(posedge clk);
    t_write();
    $display("test write done");
    t_read();
    $display("test read done");
    t_busy();
    $display("test busy done");
    t_fifo();
    $display("test fifo done");
    final_report();
  end
endmodule // tb_eph_host_port
